// ===== rtl/hbsd_host_port.sv
/*
  Host byte swap and DMA request control: configuration registers on APB,
  byte lane steering between host data and the input/output buffers,
  and the DMA request pin driver.
  Assumes host mode straps come from pins, buffer and DMA request
  inputs come from logic on clk, and an APB master on clk.
*/
// Chosen here: the register addresses and the APB register port.
`timescale 1ns/1ps
module hbsd_host_port #(
  parameter bit LEGACY_REV = 1'b0
) (
  input  wire logic                      clk,
  input  wire logic                      reset,
  input  wire logic                      psel,
  input  wire logic                      penable,
  input  wire logic                      pwrite,
  input  wire logic [hbsd_pkg::ADDR_W-1:0] paddr,
  input  wire logic [hbsd_pkg::DATA_W-1:0] pwdata,
  output logic      [hbsd_pkg::DATA_W-1:0] prdata,
  output logic                           pready,
  output logic                           pslverr,
  input  wire logic [1:0]                hostModePins,
  input  wire logic                      hostWrValid,
  input  wire logic [hbsd_pkg::DATA_W-1:0] hostWrData,
  output logic                           bufWrValid,
  output logic      [hbsd_pkg::DATA_W-1:0] bufWrData,
  input  wire logic                      bufRdValid,
  input  wire logic [hbsd_pkg::DATA_W-1:0] bufRdData,
  output logic                           hostRdValid,
  output logic      [hbsd_pkg::DATA_W-1:0] hostRdData,
  input  wire logic                      dmaRequest,
  output logic                           dmaReqPin,
  output logic                           dmaReqPinOe
);

  localparam int DW = hbsd_pkg::DATA_W;

  // Byte steering serves 32-bit words only
  if (hbsd_pkg::DATA_W != 32) begin
    $error("Byte steering serves 32-bit words only");
  end

  logic [hbsd_pkg::CFG_W-1:0] hostCfg_reg;
  logic                       dmaOutEn_reg;
  logic [1:0]                 modeSync1_reg;
  logic [1:0]                 modeSync2_reg;
  logic [DW-1:0]              prdata_reg;
  logic                       pready_reg;
  logic                       pslverr_reg;
  logic                       bufWrValid_reg;
  logic [DW-1:0]              bufWrData_reg;
  logic                       hostRdValid_reg;
  logic [DW-1:0]              hostRdData_reg;
  logic                       dmaReqPin_reg;
  logic                       dmaReqPinOe_reg;

  logic                       setupPhase;
  logic                       writeTaken;
  logic                       addrHit;
  logic                       swapEnable;
  logic                       fullReverse;
  logic                       halfExchange;
  logic                       dmaAsserted;
  logic [DW-1:0]              readMux;
  logic [DW-1:0]              hostToBuf;
  logic [DW-1:0]              bufToHost;

  // Swap steering shared by both directions
  function automatic logic [31:0] steer(input logic [31:0] d,
                                        input logic        rev,
                                        input logic        half);
    logic [31:0] r;
    r = d;
    if (rev) begin
      r = {d[7:0], d[15:8], d[23:16], d[31:24]};
    end else if (half) begin
      r = {d[23:16], d[31:24], d[7:0], d[15:8]};
    end
    return r;
  endfunction

  // Mode straps from pins pass two flip-flops
  always_ff @(posedge clk) begin
    if (reset) begin
      modeSync1_reg <= hbsd_pkg::MODE_SERIAL;
      modeSync2_reg <= hbsd_pkg::MODE_SERIAL;
    end else begin
      modeSync1_reg <= hostModePins;
      modeSync2_reg <= modeSync1_reg;
    end
  end

  // Swap qualification
  always_comb begin
    swapEnable   = hostCfg_reg[hbsd_pkg::BIT_SWAP] && !LEGACY_REV;
    fullReverse  = swapEnable &&
                   (modeSync2_reg == hbsd_pkg::MODE_PAIR_RISE ||
                    modeSync2_reg == hbsd_pkg::MODE_PAIR_FALL);
    halfExchange = swapEnable &&
                   modeSync2_reg == hbsd_pkg::host_mode_halfword_swap;
  end

  assign hostToBuf = steer(hostWrData, fullReverse, halfExchange);
  assign bufToHost = steer(bufRdData, fullReverse, halfExchange);

  // Host write into input buffer
  always_ff @(posedge clk) begin
    if (reset) begin
      bufWrValid_reg <= 1'b0;
      bufWrData_reg  <= hbsd_pkg::ZERO_WORD;
    end else begin
      bufWrValid_reg <= hostWrValid;
      if (hostWrValid) begin
        bufWrData_reg <= hostToBuf;
      end
    end
  end

  // Buffer read toward host
  always_ff @(posedge clk) begin
    if (reset) begin
      hostRdValid_reg <= 1'b0;
      hostRdData_reg  <= hbsd_pkg::ZERO_WORD;
    end else begin
      hostRdValid_reg <= bufRdValid;
      if (bufRdValid) begin
        hostRdData_reg <= bufToHost;
      end
    end
  end

  // DMA request pin
  always_comb begin
    dmaAsserted = dmaRequest && hostCfg_reg[hbsd_pkg::BIT_DMA_EN];
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      dmaReqPin_reg   <= 1'b0;
      dmaReqPinOe_reg <= 1'b0;
    end else begin
      dmaReqPinOe_reg <= dmaOutEn_reg;
      if (dmaOutEn_reg) begin
        dmaReqPin_reg <= dmaAsserted ^
                         hostCfg_reg[hbsd_pkg::BIT_DMA_INV];
      end else begin
        dmaReqPin_reg <= 1'b0;
      end
    end
  end

  // APB decode
  always_comb begin
    setupPhase = psel && !penable;
    writeTaken = psel && penable && pready_reg && pwrite;
    addrHit    = paddr == hbsd_pkg::ADDR_HOST_CFG ||
                 paddr == hbsd_pkg::ADDR_DMA_OUT ||
                 paddr == hbsd_pkg::ADDR_STATUS;
    readMux = hbsd_pkg::ZERO_WORD;
    case (paddr)
      hbsd_pkg::ADDR_HOST_CFG: begin
        readMux[hbsd_pkg::CFG_W-1:0] = hostCfg_reg;
      end
      hbsd_pkg::ADDR_DMA_OUT: begin
        readMux[hbsd_pkg::BIT_DMA_OE] = dmaOutEn_reg;
      end
      hbsd_pkg::ADDR_STATUS: begin
        readMux[hbsd_pkg::STAT_MODE_MSB:hbsd_pkg::STAT_MODE_LSB] =
          modeSync2_reg;
        readMux[hbsd_pkg::STAT_SWAP_ACT] = fullReverse || halfExchange;
        readMux[hbsd_pkg::STAT_DMA_PIN]  = dmaReqPin_reg;
        readMux[hbsd_pkg::STAT_DMA_DRV]  = dmaReqPinOe_reg;
      end
      default: begin
        readMux = hbsd_pkg::ZERO_WORD;
      end
    endcase
  end

  // APB answer: ready in the first access cycle
  always_ff @(posedge clk) begin
    if (reset) begin
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg  <= hbsd_pkg::ZERO_WORD;
    end else begin
      pready_reg  <= setupPhase;
      pslverr_reg <= setupPhase && !addrHit;
      if (setupPhase && !pwrite) begin
        prdata_reg <= readMux;
      end else if (!psel) begin
        prdata_reg <= hbsd_pkg::ZERO_WORD;
      end
    end
  end

  // Configuration registers
  always_ff @(posedge clk) begin
    if (reset) begin
      hostCfg_reg <= hbsd_pkg::CFG_RESET;
    end else if (writeTaken && paddr == hbsd_pkg::ADDR_HOST_CFG) begin
      hostCfg_reg <= pwdata[hbsd_pkg::CFG_W-1:0] &
                     hbsd_pkg::CFG_WRITE_MASK;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      dmaOutEn_reg <= 1'b0;
    end else if (writeTaken && paddr == hbsd_pkg::ADDR_DMA_OUT) begin
      dmaOutEn_reg <= pwdata[hbsd_pkg::BIT_DMA_OE];
    end
  end

  assign prdata      = prdata_reg;
  assign pready      = pready_reg;
  assign pslverr     = pslverr_reg;
  assign bufWrValid  = bufWrValid_reg;
  assign bufWrData   = bufWrData_reg;
  assign hostRdValid = hostRdValid_reg;
  assign hostRdData  = hostRdData_reg;
  assign dmaReqPin   = dmaReqPin_reg;
  assign dmaReqPinOe = dmaReqPinOe_reg;

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  chk_cfg_upper_zero: assert property (
    hostCfg_reg[hbsd_pkg::CFG_W-1:4] == 12'h000)
    else $error("Reserved config bits not zero");

  chk_write_plain: assert property (
    hostWrValid && !fullReverse && !halfExchange
    |=> bufWrValid && bufWrData == $past(hostWrData))
    else $error("Unswapped write altered");

  chk_read_plain: assert property (
    bufRdValid && !fullReverse && !halfExchange
    |=> hostRdValid && hostRdData == $past(bufRdData))
    else $error("Unswapped read altered");

  chk_write_reverse: assert property (
    hostWrValid && fullReverse
    |=> bufWrData[31:24] == $past(hostWrData[7:0]) &&
        bufWrData[23:16] == $past(hostWrData[15:8]) &&
        bufWrData[15:8] == $past(hostWrData[23:16]) &&
        bufWrData[7:0] == $past(hostWrData[31:24]))
    else $error("Full reverse write wrong");

  chk_read_reverse: assert property (
    bufRdValid && fullReverse
    |=> hostRdData[31:24] == $past(bufRdData[7:0]) &&
        hostRdData[23:16] == $past(bufRdData[15:8]) &&
        hostRdData[15:8] == $past(bufRdData[23:16]) &&
        hostRdData[7:0] == $past(bufRdData[31:24]))
    else $error("Full reverse read wrong");

  chk_write_half: assert property (
    hostWrValid && halfExchange
    |=> bufWrData[15:8] == $past(hostWrData[7:0]) &&
        bufWrData[7:0] == $past(hostWrData[15:8]) &&
        bufWrData[31:24] == $past(hostWrData[23:16]) &&
        bufWrData[23:16] == $past(hostWrData[31:24]))
    else $error("Halfword write exchange wrong");

  chk_read_half: assert property (
    bufRdValid && halfExchange
    |=> hostRdData[15:8] == $past(bufRdData[7:0]) &&
        hostRdData[7:0] == $past(bufRdData[15:8]) &&
        hostRdData[31:24] == $past(bufRdData[23:16]) &&
        hostRdData[23:16] == $past(bufRdData[31:24]))
    else $error("Halfword read exchange wrong");

  chk_serial_noswap: assert property (
    modeSync2_reg == hbsd_pkg::MODE_SERIAL |-> !fullReverse && !halfExchange)
    else $error("Swap active in serial mode");

  chk_dma_level: assert property (
    dmaOutEn_reg && $stable(dmaOutEn_reg) |=>
    dmaReqPin == ($past(dmaAsserted) ^
                  $past(hostCfg_reg[hbsd_pkg::BIT_DMA_INV])))
    else $error("DMA request level wrong");

  chk_dma_quiet: assert property (
    dmaOutEn_reg && !hostCfg_reg[hbsd_pkg::BIT_DMA_EN] |=>
    dmaReqPin == $past(hostCfg_reg[hbsd_pkg::BIT_DMA_INV]))
    else $error("DMA request while disabled");

  chk_dma_off: assert property (
    !dmaOutEn_reg |=> !dmaReqPinOe && !dmaReqPin)
    else $error("DMA pin driven without output enable");

  chk_dma_drive: assert property (
    dmaOutEn_reg |=> dmaReqPinOe)
    else $error("DMA pin not driven with output enable");

  chk_cfg_read_zero: assert property (
    psel && !penable && !pwrite && paddr == hbsd_pkg::ADDR_HOST_CFG
    |=> prdata[hbsd_pkg::DATA_W-1:hbsd_pkg::BIT_SWAP+1] == '0)
    else $error("Reserved config bits read nonzero");

  chk_apb_unmapped: assert property (
    psel && !penable && !addrHit |=> pready && pslverr)
    else $error("Unmapped access not refused");

  chk_legacy_swap: assert property (
    LEGACY_REV |-> !swapEnable)
    else $error("Swap on earlier revision");

  chk_apb_ready: assert property (
    psel && !penable |=> pready ##1 !pready)
    else $error("APB ready timing wrong");

endmodule

// ===== rtl/hbsd_pkg.sv
/*
  Constants for the host byte swap and DMA request control block:
  register offsets, field positions, reset values and host mode codes.
  Assumes a 32-bit APB register bus and a 100 MHz system clock.
*/
// Overview of operation
// - Upper twelve config bits read as zero; software writes zero.
// - Swap disabled: host data moves to and from buffers unchanged.
// - Paired modes, swap on: host writes fully reverse all four bytes.
// - Paired modes, swap on: buffer reads fully reverse all four bytes.
// - Halfword mode, swap on: host writes exchange bytes in each halfword.
// - Halfword mode, swap on: buffer reads exchange bytes in each halfword.
// - Swapping applies only in 16-bit parallel modes, never serial mode.
// - DMA request drives high when polarity bit is zero, else low.
// - DMA requests reach the host only while enable bit is one.
// - Polarity and enable act only while DMA output enable is set.
// - Earlier revisions treat the swap enable bit as zero.
package hbsd_pkg;

  localparam int DATA_W = 32;
  localparam int ADDR_W = 12;
  localparam int CFG_W  = 16;

  // Register byte addresses
  localparam logic [ADDR_W-1:0] ADDR_HOST_CFG   = 12'h000;
  localparam logic [ADDR_W-1:0] ADDR_DMA_OUT    = 12'h004;
  localparam logic [ADDR_W-1:0] ADDR_STATUS     = 12'h008;

  // Host interface configuration fields
  localparam int BIT_SWAP      = 3;
  localparam int BIT_DMA_INV   = 2;
  localparam int BIT_DMA_EN    = 1;
  localparam logic [CFG_W-1:0] CFG_WRITE_MASK = 16'h000E;
  localparam logic [CFG_W-1:0] CFG_RESET      = 16'h0000;

  // DMA output register field
  localparam int BIT_DMA_OE    = 0;

  // Status register fields
  localparam int STAT_MODE_LSB = 0;
  localparam int STAT_MODE_MSB = 1;
  localparam int STAT_SWAP_ACT = 2;
  localparam int STAT_DMA_PIN  = 3;
  localparam int STAT_DMA_DRV  = 4;

  // Host bus mode codes, as strapped on the mode pins
  localparam logic [1:0] MODE_PAIR_RISE       = 2'h0;
  localparam logic [1:0] MODE_PAIR_FALL       = 2'h1;
  localparam logic [1:0] host_mode_halfword_swap = 2'h2;
  localparam logic [1:0] MODE_SERIAL          = 2'h3;

  localparam logic [DATA_W-1:0] ZERO_WORD = 32'h0000_0000;

endpackage

// ===== bench/hbsd_host_model.sv
/*
  Host and buffer side model: sends one word on the host write path and
  the buffer read path, and captures the steered words that come back.
  Assumes the block answers each pulse on clk a few edges later.
*/
`timescale 1ns/1ps
module hbsd_host_model (
  input  wire logic        clk,
  output logic             hostWrValid,
  output logic [31:0]      hostWrData,
  output logic             bufRdValid,
  output logic [31:0]      bufRdData,
  input  wire logic        bufWrValid,
  input  wire logic [31:0] bufWrData,
  input  wire logic        hostRdValid,
  input  wire logic [31:0] hostRdData
);
  logic [31:0] gotWr;
  logic [31:0] gotRd;
  int          nWr = 0;
  int          nRd = 0;

  initial begin
    hostWrValid = 1'b0;
    bufRdValid  = 1'b0;
    hostWrData  = 32'h0;
    bufRdData   = 32'h0;
  end

  // Capture steered words
  always @(posedge clk) begin
    if (bufWrValid) begin
      gotWr <= bufWrData;
      nWr   <= nWr + 1;
    end
    if (hostRdValid) begin
      gotRd <= hostRdData;
      nRd   <= nRd + 1;
    end
  end

  // One pulse on both paths; data lines scrambled afterwards
  task send(input logic [31:0] w);
    @(posedge clk);
    hostWrValid <= 1'b1;
    hostWrData  <= w;
    bufRdValid  <= 1'b1;
    bufRdData   <= w;
    @(posedge clk);
    hostWrValid <= 1'b0;
    bufRdValid  <= 1'b0;
    hostWrData  <= ~w;
    bufRdData   <= ~w;
  endtask
endmodule

// ===== bench/tb_host_byte_swap_dma_request_ctrl.sv
/*
  Testbench: register access, byte steering per mode and DMA pin control.
  Assumes the APB slave answers with pready and the model file is compiled.
*/
`timescale 1ns/1ps
module tb_host_byte_swap_dma_request_ctrl;
  logic clk = 1'b0, reset = 1'b1, psel = 1'b0, penable = 1'b0;
  logic pwrite = 1'b0, pready, pslverr, bufWrValid, hostRdValid;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, bufWrData, hostRdData;
  logic [31:0] hostWrData, bufRdData, rd, oldWrData, oldRdData;
  logic [1:0]  hostModePins = 2'h3;
  logic        hostWrValid, bufRdValid, err, dmaReqPin, dmaReqPinOe;
  logic        dmaRequest = 1'b0;
  int          fails = 0, checks = 0;

  always #5 clk = ~clk;

  hbsd_host_port uut (.clk(clk), .reset(reset), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .hostModePins(hostModePins), .hostWrValid(hostWrValid),
    .hostWrData(hostWrData), .bufWrValid(bufWrValid),
    .bufWrData(bufWrData), .bufRdValid(bufRdValid), .bufRdData(bufRdData),
    .hostRdValid(hostRdValid), .hostRdData(hostRdData),
    .dmaRequest(dmaRequest), .dmaReqPin(dmaReqPin),
    .dmaReqPinOe(dmaReqPinOe));

  hbsd_host_port #(.LEGACY_REV(1'b1)) uutOld (.clk(clk), .reset(reset),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(), .pready(), .pslverr(),
    .hostModePins(hostModePins), .hostWrValid(hostWrValid),
    .hostWrData(hostWrData), .bufWrValid(), .bufWrData(oldWrData),
    .bufRdValid(bufRdValid), .bufRdData(bufRdData), .hostRdValid(),
    .hostRdData(oldRdData), .dmaRequest(dmaRequest), .dmaReqPin(),
    .dmaReqPinOe());

  hbsd_host_model host (.clk(clk), .hostWrValid(hostWrValid),
    .hostWrData(hostWrData), .bufRdValid(bufRdValid),
    .bufRdData(bufRdData), .bufWrValid(bufWrValid), .bufWrData(bufWrData),
    .hostRdValid(hostRdValid), .hostRdData(hostRdData));

  task report_and_stop;
    $display("checks=%0d fails=%0d", checks, fails);
    if (fails == 0 && checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  task cmp(input logic [31:0] g, input logic [31:0] e);
    checks++;
    if (g !== e) begin
      fails++;
      $display("MISMATCH t=%0t got %h exp %h", $time, g, e);
    end
  endtask

  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    for (n = 0; n < 20; n++) begin
      @(posedge clk);
      if (pready === 1'b1) break;
    end
    if (n == 20) begin
      fails++;
      report_and_stop();
    end
    rd = prdata; err = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask

  function automatic logic [31:0] steer(logic [31:0] w, logic [1:0] m,
                                        logic s);
    if (!s || m == hbsd_pkg::MODE_SERIAL) return w;
    if (m == hbsd_pkg::host_mode_halfword_swap)
      return {w[23:16], w[31:24], w[7:0], w[15:8]};
    return {w[7:0], w[15:8], w[23:16], w[31:24]};
  endfunction

  task t_regs;
    apb(1'b0, hbsd_pkg::ADDR_HOST_CFG, 32'h0);
    cmp(rd, 32'h0);
    apb(1'b1, hbsd_pkg::ADDR_HOST_CFG, 32'h0000_000E);
    apb(1'b0, hbsd_pkg::ADDR_HOST_CFG, 32'h0);
    cmp(rd, 32'h0000_000E);
    apb(1'b0, 12'h00C, 32'h0);
    cmp({31'h0, err}, 32'h1);
    cmp(rd, 32'h0);
  endtask

  task t_swap;
    logic [31:0] e;
    logic        sw;
    for (int m = 0; m < 4; m++) begin
      for (int s = 0; s < 2; s++) begin
        hostModePins <= m[1:0];
        apb(1'b1, hbsd_pkg::ADDR_HOST_CFG, {28'h0, s[0], 3'h0});
        repeat (3) @(posedge clk);
        host.send(32'h1122_3344);
        repeat (3) @(posedge clk);
        e = steer(32'h1122_3344, m[1:0], s[0]);
        cmp(host.gotWr, e);
        cmp(host.gotRd, e);
        cmp(host.nWr, 2 * m + s + 1);
        cmp(host.nRd, 2 * m + s + 1);
        cmp(oldWrData, 32'h1122_3344);
        cmp(oldRdData, 32'h1122_3344);
        sw = s[0] && (m[1:0] != hbsd_pkg::MODE_SERIAL);
        apb(1'b0, hbsd_pkg::ADDR_STATUS, 32'h0);
        cmp(rd, {29'h0, sw, m[1:0]});
      end
    end
  endtask

  task t_dma;
    logic [3:0] c;
    for (int i = 0; i < 16; i++) begin
      c = i[3:0];
      apb(1'b1, hbsd_pkg::ADDR_HOST_CFG, {29'h0, c[2], c[1], 1'b0});
      apb(1'b1, hbsd_pkg::ADDR_DMA_OUT, {31'h0, c[3]});
      dmaRequest <= c[0];
      repeat (3) @(posedge clk);
      #1;
      cmp({30'h0, dmaReqPinOe, dmaReqPin},
          {30'h0, c[3], c[3] & ((c[0] & c[1]) ^ c[2])});
      apb(1'b0, hbsd_pkg::ADDR_DMA_OUT, 32'h0);
      cmp(rd, {31'h0, c[3]});
    end
  endtask

  initial begin
    repeat (4) @(posedge clk);
    reset <= 1'b0;
    t_regs();
    t_swap();
    t_dma();
    report_and_stop();
  end
endmodule
